// ===== rtl/era_consts.vh
// constants for the e3 receive alarm interrupt block
`ifndef ERA_CONSTS_VH
`define ERA_CONSTS_VH

// ==========================================================
// register indices (byte address is four times the index)
`define ERA_IDX_CFG_STATUS_TWO  6'h11
`define ERA_IDX_IRQ_ENABLE_ONE  6'h12
`define ERA_IDX_IRQ_ENABLE_TWO  6'h13
`define ERA_IDX_IRQ_STATUS_ONE  6'h14
`define ERA_IDX_IRQ_STATUS_TWO  6'h15

// ==========================================================
// field positions
`define ERA_BIT_LOF_ALGO        7
`define ERA_BIT_OOF_STATE       5
`define ERA_BIT_AIS_STATE       3
`define ERA_BIT_FERF_STATE      0
`define ERA_BIT_AIS_IRQ         0
`define ERA_BIT_ALIGNMENT_CHANGE_IRQ        4
`define ERA_BIT_FERF_IRQ        3
`define ERA_BIT_EN2_SPARE       7

// ==========================================================
// reset values
`define ERA_RST_ENABLE          8'h00
`define ERA_RST_STATUS          3'h0

// ==========================================================
// detection counts
`define ERA_AIS_MAX_ZEROS       4'h7
`define ERA_ZERO_CNT_SAT        4'h8
`define ERA_AIS_FRAMES          2'h2
`define ERA_OOF_FRAMES          3'h4

// ==========================================================
// axi responses
`define ERA_RESP_OKAY           2'h0
`define ERA_RESP_SLVERR         2'h2

`endif

// ===== rtl/era_zero_monitor.v
// per-frame zero density monitor deciding the AIS state
`timescale 1ns/10ps
`default_nettype none
`include "era_consts.vh"

module era_zero_monitor
(
  // clock and reset
  input  wire       sys_clk_i,
  input  wire       rst_b_i,
  // receive stream
  input  wire       bit_valid_i,
  input  wire       bit_data_i,
  input  wire       frame_end_i,
  // result
  output reg        ais_state_o,
  output reg        ais_change_o
);

  // ==========================================================
  // zero counting
  reg  [3:0] zero_cnt;
  reg  [1:0] low_run;
  reg  [1:0] high_run;
  wire       is_zero;
  wire [3:0] frame_zeros;
  wire       frame_low;
  wire [1:0] next_low_run;
  wire [1:0] next_high_run;
  wire       next_ais;

  assign is_zero = bit_valid_i & ~bit_data_i;
  // saturate at eight: only the seven-or-less threshold matters
  assign frame_zeros = (is_zero && zero_cnt != `ERA_ZERO_CNT_SAT) ?
                       zero_cnt + 4'h1 : zero_cnt;
  assign frame_low = (frame_zeros <= `ERA_AIS_MAX_ZEROS);
  assign next_low_run  = frame_low ?
                         ((low_run == `ERA_AIS_FRAMES) ? low_run : low_run + 2'h1) : 2'h0;
  assign next_high_run = ~frame_low ?
                         ((high_run == `ERA_AIS_FRAMES) ? high_run : high_run + 2'h1) : 2'h0;
  assign next_ais = (next_low_run == `ERA_AIS_FRAMES) ? 1'b1 :
                    (next_high_run == `ERA_AIS_FRAMES) ? 1'b0 : ais_state_o;

  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      zero_cnt     <= 4'h0;
      low_run      <= 2'h0;
      high_run     <= 2'h0;
      ais_state_o  <= 1'b0;
      ais_change_o <= 1'b0;
    end
    else
    begin
      ais_change_o <= 1'b0;
      if (frame_end_i)
      begin
        zero_cnt     <= 4'h0;
        low_run      <= next_low_run;
        high_run     <= next_high_run;
        ais_state_o  <= next_ais;
        ais_change_o <= next_ais ^ ais_state_o;
      end
      else
      begin
        zero_cnt <= frame_zeros;
      end
    end
  end

endmodule
`default_nettype wire

// ===== rtl/era_rx_alarm_irq.v
// receive alarm interrupt logic with axi4-lite register slave
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "era_consts.vh"

module era_rx_alarm_irq
(
  // clock and reset
  input  wire        sys_clk_i,
  input  wire        rst_b_i,
  // receive framer events
  input  wire        rx_bit_valid_i,
  input  wire        rx_bit_i,
  input  wire        frame_end_i,
  input  wire        a_bit_i,
  input  wire        fas_error_i,
  input  wire        sync_found_i,
  input  wire        sync_new_position_i,
  // framer state outputs
  output wire        rx_frame_lost_state_o,
  output wire        hold_old_alignment_o,
  output wire        frame_loss_algorithm_select_o,
  // interrupt request
  output wire        irq_b_o,
  // axi4-lite write address
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // axi4-lite read address
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  // axi4-lite read data
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp
);

  // ==========================================================
  // AIS detection
  wire ais_state;
  wire ais_change;

  era_zero_monitor u_zero_monitor
  (
    .sys_clk_i    (sys_clk_i),
    .rst_b_i      (rst_b_i),
    .bit_valid_i  (rx_bit_valid_i),
    .bit_data_i   (rx_bit_i),
    .frame_end_i  (frame_end_i),
    .ais_state_o  (ais_state),
    .ais_change_o (ais_change)
  );

  // ==========================================================
  // far-end failure detection
  reg ferf_state;
  reg ferf_change;

  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ferf_state  <= 1'b0;
      ferf_change <= 1'b0;
    end
    else
    begin
      ferf_change <= 1'b0;
      if (frame_end_i)
      begin
        ferf_state  <= a_bit_i;
        ferf_change <= a_bit_i ^ ferf_state;
      end
    end
  end

  // ==========================================================
  // out-of-frame and alignment change
  reg  [2:0] fas_err_run;
  reg        oof_state;
  reg        alignment_change_event;
  wire [2:0] next_fas_err_run;

  assign next_fas_err_run = !fas_error_i ? 3'h0 :
                            (fas_err_run == `ERA_OOF_FRAMES) ? fas_err_run :
                            fas_err_run + 3'h1;

  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      fas_err_run <= 3'h0;
      oof_state   <= 1'b0;
      alignment_change_event  <= 1'b0;
    end
    else
    begin
      // old position reacquired gives no event
      alignment_change_event <= oof_state & sync_found_i & sync_new_position_i;
      if (oof_state && sync_found_i)
      begin
        oof_state   <= 1'b0;
        fas_err_run <= 3'h0;
      end
      else if (frame_end_i)
      begin
        fas_err_run <= next_fas_err_run;
        if (next_fas_err_run == `ERA_OOF_FRAMES)
        begin
          oof_state <= 1'b1;
        end
      end
    end
  end

  assign rx_frame_lost_state_o = oof_state;
  // payload extraction keeps the previous alignment while out of frame
  assign hold_old_alignment_o  = oof_state;

  // ==========================================================
  // axi4-lite write channel
  reg        aw_held;
  reg        w_held;
  reg  [5:0] aw_idx;
  reg  [7:0] w_byte;
  reg        w_lane0;
  reg  [7:0] enable_one;
  reg  [7:0] enable_two;
  reg        lof_algo;
  wire       do_write;
  wire       wr_hit;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign wr_hit = (aw_idx >= `ERA_IDX_CFG_STATUS_TWO) &&
                  (aw_idx <= `ERA_IDX_IRQ_STATUS_TWO);

  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_idx       <= 6'h00;
      w_byte       <= 8'h00;
      w_lane0      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ERA_RESP_OKAY;
      enable_one   <= `ERA_RST_ENABLE;
      enable_two   <= `ERA_RST_ENABLE;
      lof_algo     <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `ERA_RESP_OKAY : `ERA_RESP_SLVERR;
        if (w_lane0)
        begin
          if (aw_idx == `ERA_IDX_CFG_STATUS_TWO)
          begin
            lof_algo <= w_byte[`ERA_BIT_LOF_ALGO];
          end
          else if (aw_idx == `ERA_IDX_IRQ_ENABLE_ONE)
          begin
            enable_one <= {3'h0, w_byte[4:0]};
          end
          else if (aw_idx == `ERA_IDX_IRQ_ENABLE_TWO)
          begin
            enable_two <= {w_byte[7], 3'h0, w_byte[3:1], 1'b0};
          end
        end
      end
    end
  end

  assign frame_loss_algorithm_select_o = lof_algo;

  // ==========================================================
  // sticky status: bit 0 AIS, bit 1 alignment change, bit 2 far-end
  wire [2:0] status;
  wire [2:0] irq_set;
  wire [2:0] irq_clr;
  wire [2:0] irq_en;
  wire       rd_take;
  wire [5:0] rd_idx;
  wire       rd_status_one;
  wire       rd_status_two;

  assign rd_take = s_axi_arvalid & s_axi_arready;
  assign rd_idx  = s_axi_araddr[7:2];
  assign rd_status_one = rd_take && (rd_idx == `ERA_IDX_IRQ_STATUS_ONE);
  assign rd_status_two = rd_take && (rd_idx == `ERA_IDX_IRQ_STATUS_TWO);
  assign irq_en  = {enable_two[`ERA_BIT_FERF_IRQ],
                    enable_one[`ERA_BIT_ALIGNMENT_CHANGE_IRQ],
                    enable_one[`ERA_BIT_AIS_IRQ]};
  assign irq_set = {ferf_change, alignment_change_event, ais_change} & irq_en;
  assign irq_clr = {rd_status_two, rd_status_one, rd_status_one};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_status
      // one flop per entry keeps a single driver for each status bit
      reg sticky;
      always @(posedge sys_clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          sticky <= 1'b0;
        end
        else if (irq_set[gi])
        begin
          // a new event beats a clearing read in the same cycle
          sticky <= 1'b1;
        end
        else if (irq_clr[gi])
        begin
          sticky <= 1'b0;
        end
      end
      assign status[gi] = sticky;
    end
  endgenerate

  assign irq_b_o = ~|(status & irq_en);

  // ==========================================================
  // axi4-lite read channel
  reg [7:0] rd_byte;
  reg       rd_hit;

  assign s_axi_arready = ~s_axi_rvalid;

  always @*
  begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    if (rd_idx == `ERA_IDX_CFG_STATUS_TWO)
    begin
      rd_byte[`ERA_BIT_LOF_ALGO]   = lof_algo;
      rd_byte[`ERA_BIT_OOF_STATE]  = oof_state;
      rd_byte[`ERA_BIT_AIS_STATE]  = ais_state;
      rd_byte[`ERA_BIT_FERF_STATE] = ferf_state;
    end
    else if (rd_idx == `ERA_IDX_IRQ_ENABLE_ONE)
    begin
      rd_byte = enable_one;
    end
    else if (rd_idx == `ERA_IDX_IRQ_ENABLE_TWO)
    begin
      rd_byte = enable_two;
    end
    else if (rd_idx == `ERA_IDX_IRQ_STATUS_ONE)
    begin
      rd_byte[`ERA_BIT_AIS_IRQ]  = status[0];
      rd_byte[`ERA_BIT_ALIGNMENT_CHANGE_IRQ] = status[1];
    end
    else if (rd_idx == `ERA_IDX_IRQ_STATUS_TWO)
    begin
      rd_byte[`ERA_BIT_FERF_IRQ] = status[2];
    end
    else
    begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `ERA_RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= rd_hit ? `ERA_RESP_OKAY : `ERA_RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== sim/era_rx_alarm_irq_properties.sv
// assertion checker for the receive alarm interrupt block
`timescale 1ns/10ps
`default_nettype none
module era_rx_alarm_irq_chk
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // framer side
  input wire logic frame_end_i,
  input wire logic fas_error_i,
  input wire logic sync_found_i,
  input wire logic rx_frame_lost_state_o,
  input wire logic hold_old_alignment_o,
  input wire logic irq_b_o,
  // bus handshakes
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready
);
  logic [2:0] err_run;
  logic       wr_hs;
  logic       rd_hs;
  assign wr_hs = s_axi_wvalid && s_axi_wready;
  assign rd_hs = s_axi_arvalid && s_axi_arready;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ====
  // errored frame run; not cleared by resync, so it never undercounts
  always @(posedge sys_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      err_run <= 3'h0;
    else if (frame_end_i)
      err_run <= !fas_error_i ? 3'h0 : err_run + {2'h0, err_run != 3'h7};
  // ====
  // assertions
  AST_HOLD: assert property (hold_old_alignment_o == rx_frame_lost_state_o)
    else $error("alignment hold differs from out of frame");
  AST_OOF_AT_FRAME: assert property ($rose(rx_frame_lost_state_o) |->
    $past(frame_end_i && fas_error_i)) else $error("out of frame not at errored frame end");
  AST_OOF_RUN: assert property ($rose(rx_frame_lost_state_o) |-> err_run >= 3'h4)
    else $error("out of frame before four errored frames");
  AST_OOF_KEEP: assert property (rx_frame_lost_state_o && !sync_found_i |=>
    rx_frame_lost_state_o) else $error("out of frame left without resync");
  AST_OOF_LEAVE: assert property (rx_frame_lost_state_o && sync_found_i |=>
    !rx_frame_lost_state_o) else $error("resync did not end out of frame");
  AST_IRQ_FALL: assert property ($fell(irq_b_o) |-> $past(frame_end_i, 2) ||
    $past(sync_found_i, 2) || $past(wr_hs) || $past(wr_hs, 2))
    else $error("irq asserted without an event");
  AST_IRQ_RISE: assert property ($rose(irq_b_o) |-> $past(rd_hs) ||
    $past(rd_hs, 2) || $past(wr_hs) || $past(wr_hs, 2))
    else $error("irq released without host access");
  AST_IRQ_HOLD: assert property (!irq_b_o && !rd_hs && !wr_hs && !$past(wr_hs) |=> !irq_b_o)
    else $error("irq released while status pending");
endmodule
bind era_rx_alarm_irq era_rx_alarm_irq_chk u_era_rx_alarm_irq_chk
(
  .sys_clk_i            (sys_clk_i),
  .rst_b_i              (rst_b_i),
  .frame_end_i          (frame_end_i),
  .fas_error_i          (fas_error_i),
  .sync_found_i         (sync_found_i),
  .rx_frame_lost_state_o(rx_frame_lost_state_o),
  .hold_old_alignment_o (hold_old_alignment_o),
  .irq_b_o              (irq_b_o),
  .s_axi_wvalid         (s_axi_wvalid),
  .s_axi_wready         (s_axi_wready),
  .s_axi_arvalid        (s_axi_arvalid),
  .s_axi_arready        (s_axi_arready)
);
`default_nettype wire

// ===== sim/era_frame_src.sv
// far-end e3 frame stream model
`timescale 1ns/10ps
`default_nettype none
module era_frame_src
(
  // clock
  input  wire logic sys_clk_i,
  // receive stream
  output var logic  bit_valid_o,
  output var logic  bit_o,
  output var logic  frame_end_o,
  output var logic  a_bit_o,
  output var logic  fas_error_o,
  // resync
  output var logic  sync_found_o,
  output var logic  sync_new_o
);
  initial
  begin
    {bit_valid_o, bit_o, frame_end_o, a_bit_o} = 4'h0;
    {fas_error_o, sync_found_o, sync_new_o} = 3'h0;
  end
  // ====
  // 16-bit frame, zeros first; idle lines show the inverse
  task automatic send(input int zeros, input logic a, input logic err);
    for (int i = 0; i < 16; i++)
    begin
      bit_valid_o <= 1'b1;
      bit_o <= (i >= zeros);
      frame_end_o <= (i == 15);
      a_bit_o <= (i == 15) ? a : ~a;
      fas_error_o <= (i == 15) ? err : ~err;
      @(posedge sys_clk_i);
    end
    bit_valid_o <= 1'b0;
    frame_end_o <= 1'b0;
    bit_o <= ~bit_o;
    @(posedge sys_clk_i);
  endtask
  // ====
  // one-cycle resync pulse
  task automatic resync(input logic newpos);
    sync_found_o <= 1'b1;
    sync_new_o <= newpos;
    @(posedge sys_clk_i);
    sync_found_o <= 1'b0;
    sync_new_o <= ~newpos;
    @(posedge sys_clk_i);
  endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the receive alarm interrupt block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk, rst_b_i, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
  logic        bvld, rbit, fend, abit, ferr, sfnd, snew, lost, hold, algo, irq;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0]  bs, rs;
  logic [33:0] q[$];
  int          n_fail, samples_checked, cyc;
  era_frame_src u_era_frame_src (.sys_clk_i(clk), .bit_valid_o(bvld), .bit_o(rbit),
    .frame_end_o(fend), .a_bit_o(abit), .fas_error_o(ferr), .sync_found_o(sfnd),
    .sync_new_o(snew));
  era_rx_alarm_irq u_era_rx_alarm_irq (.sys_clk_i(clk), .rst_b_i(rst_b_i),
    .rx_bit_valid_i(bvld), .rx_bit_i(rbit), .frame_end_i(fend), .a_bit_i(abit),
    .fas_error_i(ferr), .sync_found_i(sfnd), .sync_new_position_i(snew),
    .rx_frame_lost_state_o(lost), .hold_old_alignment_o(hold),
    .frame_loss_algorithm_select_o(algo), .irq_b_o(irq), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_bresp(bs), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rs));
  // ====
  // checking and closing
  task chk(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ====
  // bus master; read results are noted and judged by the monitor
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= {24'h0, d};
    br <= 1'b1;
    while (pa || pw)
    begin
      @(posedge clk);
      pa = pa && !awr;
      pw = pw && !wrd;
      awv <= pa;
      wv <= pw;
    end
    do @(posedge clk); while (!bv);
    br <= 1'b0;
    chk({32'h0, bs}, {32'h0, r});
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [33:0] e);
    q.push_back(e);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rr <= 1'b0;
    @(posedge clk);
  endtask
  always @(posedge clk)
    if (rv && rr)
      chk({rs, rdat}, q.pop_front());
  // ====
  // frames with a random idle gap; ok() checks irq once settled
  function int hz();
    return 8 + $urandom % 8;
  endfunction
  task fr(input int z, input logic a, input logic e);
    u_era_frame_src.send(z, a, e);
    repeat ($urandom % 3) @(posedge clk);
  endtask
  task ok(input logic e);
    @(posedge clk);
    chk({33'h0, irq}, {33'h0, e});
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      complete_run;
    end
  end
  initial
  begin
    {rst_b_i, awv, wv, br, arv, rr, awa, ara, wd} = 54'h0;
    repeat (2) @(posedge clk);
    rst_b_i <= 1'b1;
    @(posedge clk);
    void'($urandom(32'h4e46));
    for (int i = 0; i < 5; i++)
      rd(8'h44 + 8'(4 * i), 34'h0);
    rd(8'h60, {2'h2, 32'h0});
    wr(8'h60, 8'hff, 2'h2);
    wr(8'h48, 8'hff, 2'h0);
    rd(8'h48, 34'h1f);
    wr(8'h4c, 8'h08, 2'h0);
    rd(8'h4c, 34'h08);
    wr(8'h44, 8'h80, 2'h0);
    wr(8'h50, 8'hff, 2'h0);
    rd(8'h50, 34'h0);
    chk({33'h0, algo}, 34'h1);
    $display("test registers done");
    fr(7, 0, 0);
    ok(1);
    fr(7, 0, 0);
    ok(0);
    rd(8'h44, 34'h88);
    rd(8'h50, 34'h01);
    ok(1);
    fr(8, 0, 0);
    fr(0, 0, 0);
    fr(8, 0, 0);
    ok(1);
    fr(hz(), 0, 0);
    ok(0);
    rd(8'h44, 34'h80);
    rd(8'h50, 34'h01);
    $display("test ais done");
    fr(hz(), 1, 0);
    ok(0);
    rd(8'h44, 34'h81);
    rd(8'h54, 34'h08);
    fr(hz(), 1, 0);
    ok(1);
    fr(hz(), 0, 0);
    rd(8'h54, 34'h08);
    wr(8'h4c, 8'h00, 2'h0);
    fr(hz(), 1, 0);
    ok(1);
    rd(8'h54, 34'h0);
    $display("test ferf done");
    for (int k = 1; k >= 0; k--)
    begin
      wr(8'h48, k ? 8'h11 : 8'h01, 2'h0);
      repeat (3) fr(hz(), 0, 1);
      chk({33'h0, lost}, 34'h0);
      fr(hz(), 0, 1);
      chk({32'h0, lost, hold}, 34'h3);
      u_era_frame_src.resync(1);
      ok(!k);
      rd(8'h50, k ? 34'h10 : 34'h0);
    end
    wr(8'h48, 8'h11, 2'h0);
    repeat (4) fr(hz(), 0, 1);
    u_era_frame_src.resync(0);
    ok(1);
    chk({33'h0, lost}, 34'h0);
    u_era_frame_src.resync(1);
    ok(1);
    rd(8'h50, 34'h0);
    $display("test alignment done");
    complete_run;
  end
endmodule
`default_nettype wire
